// file: rtl/dms_defines.svh
// Purpose: Shared constants of the motion-sync digital I/O block
// Assumes: Included by bare name from every rtl file
// Notes: Register offsets are byte addresses on the plain register port
`ifndef DMS_DEFINES_SVH
`define DMS_DEFINES_SVH
// Sizes
`define DMS_AXES 3
`define DMS_BITS 24
`define DMS_PORT_W 8
`define DMS_PORT_SH 3
`define DMS_IDX_W 5
`define DMS_AW 8
`define DMS_DW 32
// Register offsets
`define DMS_A_DIR 8'h00
`define DMS_A_LKA0 8'h04
`define DMS_A_LKEN 8'h10
`define DMS_A_SSA0 8'h14
`define DMS_A_SSEN 8'h20
`define DMS_A_OUT 8'h24
`define DMS_A_PIN 8'h28
`define DMS_A_STAT 8'h2C
`define DMS_A_CLR 8'h30
`define DMS_A_IEN 8'h34
`define DMS_A_LMASK 8'h38
`define DMS_A_LIDX 8'h3C
`define DMS_A_ESC 8'h40
`define DMS_A_STEP 8'h04
// Field positions
`define DMS_IDX_F 4:0
`define DMS_LVL_POS 8
`define DMS_DIR_F 2:0
`define DMS_AX_F 2:0
`define DMS_STAT_F 3:0
`define DMS_ESC_F 1:0
`define DMS_ST_LAUNCH 3
// Reset values
`define DMS_DIR_RST 3'h0
`define DMS_AX_RST 3'h0
`define DMS_ASG_RST 6'h00
`define DMS_STAT_RST 4'h0
`define DMS_ESC_RST 2'h0
`define DMS_IDX_RST 5'h00
`define DMS_WORD_RST 32'h0000_0000
`define DMS_BITS_RST 24'h00_0000
`define DMS_PIN_IDLE 24'hff_ffff
// Direction codes used by checks
`define DMS_DIR_04 3'h4
`define DMS_OE_04 24'hff_0000
`define DMS_DIR_06 3'h6
`define DMS_OE_06 24'hff_ff00
`endif

// file: rtl/dms_pkg.sv
// Purpose: Types of the motion-sync digital I/O block
// Assumes: dms_defines.svh on the include path
// Notes: Widths come from the shared header
`include "dms_defines.svh"
package dms_pkg;
   // Per-axis interlock state
   typedef enum logic [1:0] {
      LK_CLEAR = 2'b00,
      LK_REJECT = 2'b01,
      LK_STOP = 2'b10
   } dms_lock_state_type;
   // Bit assignment: level plus I/O bit index
   typedef struct packed {
      logic level;
      logic [`DMS_IDX_W-1:0] idx;
   } dms_assign_type;
endpackage

// file: rtl/dms_evt_if.sv
// Purpose: Pin samples and launch events between top and launcher
// Assumes: One clock domain
// Notes: Top drives pin_sync and mask, launcher answers with a pulse
`timescale 1ns/1ps
`default_nettype none
`include "dms_defines.svh"
interface dms_evt_if;
   logic [`DMS_BITS-1:0] pin_sync;
   logic [`DMS_BITS-1:0] mask;
   logic launch;
   logic [`DMS_IDX_W-1:0] launch_idx;
   modport src (output pin_sync, output mask, input launch, input launch_idx);
   modport launcher (input pin_sync, input mask, output launch, output launch_idx);
endinterface
`default_nettype wire

// file: rtl/dms_sync.sv
// Purpose: Two-flop synchroniser for the I/O pins
// Assumes: Pins idle high through pull-ups
// Notes: Only the second stage leaves this module
`timescale 1ns/1ps
`default_nettype none
`include "dms_defines.svh"
module dms_sync import dms_pkg::*; (
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, high
   input wire logic [`DMS_BITS-1:0] async_in, // Raw pins
   output logic [`DMS_BITS-1:0] sync_out // Synchronised pins
);
   logic [`DMS_BITS-1:0] meta_ff, nxt_meta, sync_ff, nxt_sync;

   // Next stage values
   always_comb begin
      nxt_meta = async_in;
      nxt_sync = meta_ff;
   end

   // Stages reset to the pulled-up idle level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= `DMS_PIN_IDLE;
         sync_ff <= `DMS_PIN_IDLE;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign sync_out = sync_ff;
endmodule
`default_nettype wire

// file: rtl/dms_launch.sv
// Purpose: Falling-edge detector that launches stored programs
// Assumes: pin_sync already synchronised, mask holds input bits only
// Notes: Lowest index wins when several bits fall together
`timescale 1ns/1ps
`default_nettype none
`include "dms_defines.svh"
module dms_launch import dms_pkg::*; (
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, high
   dms_evt_if.launcher ev // Pins in, launch out
);
   logic [`DMS_BITS-1:0] prev_ff, nxt_prev, fall;
   logic launch_ff, nxt_launch;
   logic [`DMS_IDX_W-1:0] idx_ff, nxt_idx;

   // High-to-low detect on assigned bits
   always_comb begin
      fall = prev_ff & ~ev.pin_sync & ev.mask; // R10 R11
      nxt_prev = ev.pin_sync;
      nxt_launch = |fall;
      nxt_idx = idx_ff;
      for (int b = `DMS_BITS - 1; b >= 0; b--) begin
         if (fall[b]) begin
            nxt_idx = `DMS_IDX_W'(b);
         end
      end
   end

   // Previous sample resets high so release gives no false launch
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_ff <= `DMS_PIN_IDLE;
         launch_ff <= 1'b0;
         idx_ff <= `DMS_IDX_RST;
      end else begin
         prev_ff <= nxt_prev;
         launch_ff <= nxt_launch;
         idx_ff <= nxt_idx;
      end
   end

   assign ev.launch = launch_ff;
   assign ev.launch_idx = idx_ff;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   launch_edge_a: assert property ( // R11
      (|(prev_ff & ~ev.pin_sync & ev.mask)) |=> ev.launch)
      else $error("falling edge on assigned bit gave no launch");
   launch_mask_a: assert property ( // R10
      !(|(prev_ff & ~ev.pin_sync & ev.mask)) |=> !ev.launch)
      else $error("launch without an assigned falling edge");
endmodule
`default_nettype wire

// file: rtl/dms_motion_sync.sv
// Purpose: Digital I/O interlock, standstill report and program launch
// Assumes: axis_moving comes from logic on clk; pins are asynchronous
// Notes: Registers on a plain port, read data one cycle after strobe
//
// What this block does
// R1 - Enabled interlock bit at level blocks axis, errors
// R2 - Interlock keeps bit index and blocking level
// R3 - Interlock acts only while its enable set
// R4 - Stationary axis drives standstill bit to level
// R5 - Standstill keeps bit index and stationary level
// R6 - Standstill drives pin only enabled and configured
// R7 - Software sets standstill port to output
// R8 - Direction code bit per port, 1 output
// R9 - Code 04H: A,B inputs, C output
// R10 - Per-bit assignment of program launch inputs
// R11 - Launch on high-to-low pin transition
// R12 - Moving axis gets emergency stop, idle rejects
// R13 - Reset leaves every port an input
// R14 - Moving axis drives opposite standstill level
`timescale 1ns/1ps
`default_nettype none
`include "dms_defines.svh"
module dms_motion_sync import dms_pkg::*; (
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, high
   input wire logic [`DMS_AW-1:0] reg_addr, // Register byte address
   input wire logic [`DMS_DW-1:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [`DMS_DW-1:0] reg_rdata, // Read data, next cycle
   input wire logic [`DMS_BITS-1:0] io_in, // Pin levels
   output logic [`DMS_BITS-1:0] io_out, // Pin drive value
   output logic [`DMS_BITS-1:0] io_oe, // Pin drive enable
   input wire logic [`DMS_AXES-1:0] axis_moving, // Axis in motion
   output logic [`DMS_AXES-1:0] move_block, // Refuse or hold moves
   output logic [`DMS_AXES-1:0] estop_req, // Emergency stop pulse
   output logic [1:0] estop_cfg, // Emergency stop mode
   output logic launch_req, // Start stored program pulse
   output logic [`DMS_IDX_W-1:0] launch_idx, // Bit that launched
   output logic irq // Level interrupt
);
   logic [2:0] dir_ff, nxt_dir;
   dms_assign_type lka_ff [`DMS_AXES];
   dms_assign_type nxt_lka [`DMS_AXES];
   dms_assign_type ssa_ff [`DMS_AXES];
   dms_assign_type nxt_ssa [`DMS_AXES];
   logic [`DMS_AXES-1:0] lken_ff, nxt_lken, ssen_ff, nxt_ssen;
   logic [`DMS_AXES-1:0] sscfg_ff, nxt_sscfg;
   logic [`DMS_BITS-1:0] outr_ff, nxt_outr, lmask_ff, nxt_lmask;
   logic [1:0] esc_ff, nxt_esc;
   logic [3:0] stat_ff, nxt_stat, ien_ff, nxt_ien, clr, evt;
   logic [`DMS_IDX_W-1:0] lidx_ff, nxt_lidx;
   logic [`DMS_DW-1:0] rdata_ff, nxt_rdata;
   dms_lock_state_type lk_ff [`DMS_AXES];
   dms_lock_state_type nxt_lk [`DMS_AXES];
   logic [`DMS_AXES-1:0] blk_ff, nxt_blk, estop_ff, nxt_estop, hit;
   logic [`DMS_BITS-1:0] out_ff, nxt_out, oe_ff, nxt_oe, pin_s;

   dms_evt_if ev ();

   // Address of a per-axis register
   function automatic logic [7:0] axis_addr(input logic [7:0] base, input int a);
      axis_addr = base + 8'(a) * `DMS_A_STEP;
   endfunction

   // Pin level at an assigned bit; out of range never matches
   function automatic logic bit_of(input logic [`DMS_BITS-1:0] v,
                                   input dms_assign_type asg);
      bit_of = (asg.idx < `DMS_BITS) ? v[asg.idx] : ~asg.level;
   endfunction

   // Whether the port holding a bit is an output
   function automatic logic is_out(input logic [2:0] dir,
                                   input logic [`DMS_IDX_W-1:0] idx);
      is_out = (idx < `DMS_BITS) ? dir[2'(idx >> `DMS_PORT_SH)] : 1'b0;
   endfunction

   // Pin synchroniser
   dms_sync u_sync (
      .clk(clk),
      .rst(rst),
      .async_in(io_in),
      .sync_out(pin_s)
   );

   // Program launch on input bits only
   assign ev.pin_sync = pin_s;
   assign ev.mask = lmask_ff & ~oe_ff; // R10

   dms_launch u_launch (
      .clk(clk),
      .rst(rst),
      .ev(ev.launcher)
   );

   // Register writes and sticky status
   always_comb begin
      nxt_dir = dir_ff;
      nxt_lken = lken_ff;
      nxt_ssen = ssen_ff;
      nxt_sscfg = sscfg_ff;
      nxt_outr = outr_ff;
      nxt_lmask = lmask_ff;
      nxt_esc = esc_ff;
      nxt_ien = ien_ff;
      nxt_lka = lka_ff;
      nxt_ssa = ssa_ff;
      clr = `DMS_STAT_RST;
      if (reg_wr) begin
         case (reg_addr)
            `DMS_A_DIR: nxt_dir = reg_wdata[`DMS_DIR_F]; // R8
            `DMS_A_LKEN: nxt_lken = reg_wdata[`DMS_AX_F]; // R3
            `DMS_A_SSEN: nxt_ssen = reg_wdata[`DMS_AX_F]; // R6
            `DMS_A_OUT: nxt_outr = reg_wdata[`DMS_BITS-1:0];
            `DMS_A_LMASK: nxt_lmask = reg_wdata[`DMS_BITS-1:0]; // R10
            `DMS_A_ESC: nxt_esc = reg_wdata[`DMS_ESC_F];
            `DMS_A_CLR: clr = reg_wdata[`DMS_STAT_F];
            `DMS_A_IEN: nxt_ien = reg_wdata[`DMS_STAT_F];
            default: ;
         endcase
         for (int a = 0; a < `DMS_AXES; a++) begin
            if (reg_addr == axis_addr(`DMS_A_LKA0, a)) begin
               nxt_lka[a] = {reg_wdata[`DMS_LVL_POS], reg_wdata[`DMS_IDX_F]}; // R2
            end
            if (reg_addr == axis_addr(`DMS_A_SSA0, a)) begin
               nxt_ssa[a] = {reg_wdata[`DMS_LVL_POS], reg_wdata[`DMS_IDX_F]}; // R5
               nxt_sscfg[a] = 1'b1; // R6
            end
         end
      end
      // A new event wins over a clear in the same cycle
      nxt_stat = (stat_ff & ~clr) | evt;
      nxt_lidx = ev.launch ? ev.launch_idx : lidx_ff;
   end

   // Read data, zero outside a read
   always_comb begin
      nxt_rdata = `DMS_WORD_RST;
      if (reg_rd) begin
         case (reg_addr)
            `DMS_A_DIR: nxt_rdata[`DMS_DIR_F] = dir_ff;
            `DMS_A_LKEN: nxt_rdata[`DMS_AX_F] = lken_ff;
            `DMS_A_SSEN: nxt_rdata[`DMS_AX_F] = ssen_ff;
            `DMS_A_OUT: nxt_rdata[`DMS_BITS-1:0] = outr_ff;
            `DMS_A_PIN: nxt_rdata[`DMS_BITS-1:0] = pin_s;
            `DMS_A_STAT: nxt_rdata[`DMS_STAT_F] = stat_ff;
            `DMS_A_IEN: nxt_rdata[`DMS_STAT_F] = ien_ff;
            `DMS_A_LMASK: nxt_rdata[`DMS_BITS-1:0] = lmask_ff;
            `DMS_A_LIDX: nxt_rdata[`DMS_IDX_F] = lidx_ff;
            `DMS_A_ESC: nxt_rdata[`DMS_ESC_F] = esc_ff;
            default: ;
         endcase
         for (int a = 0; a < `DMS_AXES; a++) begin
            if (reg_addr == axis_addr(`DMS_A_LKA0, a)) begin
               nxt_rdata[`DMS_LVL_POS] = lka_ff[a].level;
               nxt_rdata[`DMS_IDX_F] = lka_ff[a].idx;
            end
            if (reg_addr == axis_addr(`DMS_A_SSA0, a)) begin
               nxt_rdata[`DMS_LVL_POS] = ssa_ff[a].level;
               nxt_rdata[`DMS_IDX_F] = ssa_ff[a].idx;
            end
         end
      end
   end

   // Interlock per axis
   always_comb begin
      nxt_lk = lk_ff;
      nxt_estop = `DMS_AX_RST;
      evt = `DMS_STAT_RST;
      evt[`DMS_ST_LAUNCH] = ev.launch;
      for (int a = 0; a < `DMS_AXES; a++) begin
         hit[a] = lken_ff[a] && !is_out(dir_ff, lka_ff[a].idx) // R3
                  && (bit_of(pin_s, lka_ff[a]) == lka_ff[a].level); // R1
         case (lk_ff[a])
            LK_CLEAR: begin
               if (hit[a]) begin
                  evt[a] = 1'b1; // R1
                  if (axis_moving[a]) begin
                     nxt_lk[a] = LK_STOP; // R12
                     nxt_estop[a] = 1'b1; // R12
                  end else begin
                     nxt_lk[a] = LK_REJECT; // R12
                  end
               end
            end
            LK_REJECT: begin
               if (!hit[a]) begin
                  nxt_lk[a] = LK_CLEAR;
               end else if (axis_moving[a]) begin
                  nxt_lk[a] = LK_STOP;
                  nxt_estop[a] = 1'b1;
               end
            end
            LK_STOP: begin
               if (!hit[a]) begin
                  nxt_lk[a] = LK_CLEAR;
               end
            end
            default: nxt_lk[a] = LK_CLEAR;
         endcase
         nxt_blk[a] = (nxt_lk[a] != LK_CLEAR); // R1
      end
   end

   // Pin drive: software value, overridden by standstill reports
   always_comb begin
      for (int b = 0; b < `DMS_BITS; b++) begin
         nxt_oe[b] = dir_ff[b / `DMS_PORT_W]; // R8 R9 R7
         nxt_out[b] = outr_ff[b];
         for (int a = 0; a < `DMS_AXES; a++) begin
            if (ssen_ff[a] && sscfg_ff[a] && ssa_ff[a].idx == 5'(b)) begin // R6
               nxt_out[b] = axis_moving[a] ? ~ssa_ff[a].level // R14
                                           : ssa_ff[a].level; // R4
            end
         end
      end
   end

   // State registers; direction resets to all inputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dir_ff <= `DMS_DIR_RST; // R13
         lken_ff <= `DMS_AX_RST;
         ssen_ff <= `DMS_AX_RST;
         sscfg_ff <= `DMS_AX_RST;
         outr_ff <= `DMS_BITS_RST;
         lmask_ff <= `DMS_BITS_RST;
         esc_ff <= `DMS_ESC_RST;
         ien_ff <= `DMS_STAT_RST;
         stat_ff <= `DMS_STAT_RST;
         lidx_ff <= `DMS_IDX_RST;
         rdata_ff <= `DMS_WORD_RST;
         blk_ff <= `DMS_AX_RST;
         estop_ff <= `DMS_AX_RST;
         out_ff <= `DMS_BITS_RST;
         oe_ff <= `DMS_BITS_RST;
         for (int a = 0; a < `DMS_AXES; a++) begin
            lka_ff[a] <= `DMS_ASG_RST;
            ssa_ff[a] <= `DMS_ASG_RST;
            lk_ff[a] <= LK_CLEAR;
         end
      end else begin
         dir_ff <= nxt_dir;
         lken_ff <= nxt_lken;
         ssen_ff <= nxt_ssen;
         sscfg_ff <= nxt_sscfg;
         outr_ff <= nxt_outr;
         lmask_ff <= nxt_lmask;
         esc_ff <= nxt_esc;
         ien_ff <= nxt_ien;
         stat_ff <= nxt_stat;
         lidx_ff <= nxt_lidx;
         rdata_ff <= nxt_rdata;
         blk_ff <= nxt_blk;
         estop_ff <= nxt_estop;
         out_ff <= nxt_out;
         oe_ff <= nxt_oe;
         lka_ff <= nxt_lka;
         ssa_ff <= nxt_ssa;
         lk_ff <= nxt_lk;
      end
   end

   // Outputs
   assign reg_rdata = rdata_ff;
   assign io_out = out_ff;
   assign io_oe = oe_ff;
   assign move_block = blk_ff;
   assign estop_req = estop_ff;
   assign estop_cfg = esc_ff;
   assign launch_req = ev.launch; // R11
   assign launch_idx = ev.launch_idx;
   assign irq = |(stat_ff & ien_ff);

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   lock_block_a: assert property ( // R1
      (lk_ff[0] == LK_CLEAR && hit[0]) |=> (move_block[0] && stat_ff[0]))
      else $error("interlock hit did not block and flag");
   lock_gate_a: assert property ( // R3
      !lken_ff[0] |=> !move_block[0])
      else $error("disabled interlock still blocks");
   lock_store_a: assert property ( // R2
      (reg_wr && reg_addr == `DMS_A_LKA0) |=>
      (lka_ff[0].idx == $past(reg_wdata[`DMS_IDX_F])
       && lka_ff[0].level == $past(reg_wdata[`DMS_LVL_POS])))
      else $error("interlock assignment not stored");
   stop_pulse_a: assert property ( // R12
      (lk_ff[1] == LK_CLEAR && hit[1] && axis_moving[1]) |=>
      estop_req[1] ##1 !estop_req[1])
      else $error("moving axis did not get one stop pulse");
   reject_idle_a: assert property ( // R12
      (lk_ff[1] == LK_CLEAR && hit[1] && !axis_moving[1]) |=>
      (move_block[1] && !estop_req[1]))
      else $error("idle axis not held without stop");
   ss_still_a: assert property ( // R4
      (ssen_ff[2] && sscfg_ff[2] && ssa_ff[2].idx < `DMS_BITS
       && !axis_moving[2] && !reg_wr) |=>
      io_out[$past(ssa_ff[2].idx)] == $past(ssa_ff[2].level))
      else $error("standstill level not driven");
   ss_move_a: assert property ( // R14
      (ssen_ff[2] && sscfg_ff[2] && ssa_ff[2].idx < `DMS_BITS
       && axis_moving[2] && !reg_wr) |=>
      io_out[$past(ssa_ff[2].idx)] != $past(ssa_ff[2].level))
      else $error("moving level not opposite");
   ss_store_a: assert property ( // R5
      (reg_wr && reg_addr == axis_addr(`DMS_A_SSA0, 2)) |=>
      (sscfg_ff[2] && ssa_ff[2].idx == $past(reg_wdata[`DMS_IDX_F])
       && ssa_ff[2].level == $past(reg_wdata[`DMS_LVL_POS])))
      else $error("standstill assignment not stored");
   ss_gate_a: assert property ( // R6
      (ssen_ff == `DMS_AX_RST && !reg_wr) |=> io_out == $past(outr_ff))
      else $error("pin driven while reports disabled");
   dir_reset_a: assert property ( // R13
      $past(rst) |-> io_oe == `DMS_BITS_RST)
      else $error("port not input after reset");
   dir_six_a: assert property ( // R8
      (reg_wr && reg_addr == `DMS_A_DIR && reg_wdata[`DMS_DIR_F] == `DMS_DIR_06)
      ##1 !reg_wr |=> io_oe == `DMS_OE_06)
      else $error("direction 06H mapped wrong");
   dir_four_a: assert property ( // R9
      (reg_wr && reg_addr == `DMS_A_DIR && reg_wdata[`DMS_DIR_F] == `DMS_DIR_04)
      ##1 !reg_wr |=> io_oe == `DMS_OE_04)
      else $error("direction 04H mapped wrong");
endmodule
`default_nettype wire

// file: bench/dms_pin_model.sv
// Purpose: Switches and brakes on the I/O pins of the motion-sync block
// Assumes: Every bit has a pull-up, so an undriven pin reads high
// Notes: Two drivers on one pin give an unknown level on purpose
`timescale 1ns/1ps
`default_nettype none
`include "dms_defines.svh"
module dms_pin_model (
   input wire logic [`DMS_BITS-1:0] drive_val, // Block drive value
   input wire logic [`DMS_BITS-1:0] drive_en, // Block drive enable
   input wire logic [`DMS_BITS-1:0] sw_val, // Switch level
   input wire logic [`DMS_BITS-1:0] sw_drv, // Switch closed
   output logic [`DMS_BITS-1:0] pin // Resolved pin level
);
   // Resolve each wire from both parties and the pull-up
   always_comb begin
      for (int i = 0; i < `DMS_BITS; i++) begin
         if (drive_en[i] && sw_drv[i]) begin
            pin[i] = 1'bx; // Contention shows up as a mismatch
         end else if (drive_en[i]) begin
            pin[i] = drive_val[i];
         end else if (sw_drv[i]) begin
            pin[i] = sw_val[i];
         end else begin
            pin[i] = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: bench/dms_motion_sync_tb.sv
// Purpose: Self-checking bench of the motion-sync digital I/O block
// Assumes: Register port answers reads one cycle after the strobe
// Notes: Axis, bit and level picks come from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "dms_defines.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module dms_motion_sync_tb import dms_pkg::*;;
   logic clk, rst, reg_wr, reg_rd, launch_req, irq, lv;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd_val;
   logic [23:0] io_in, io_out, io_oe, sw_val, sw_drv;
   logic [2:0] axis_moving, move_block, estop_req;
   logic [1:0] estop_cfg;
   logic [4:0] launch_idx, seen_idx;
   int error_cnt, checks_done, seed, n_stop, n_launch, ax, b, c;

   dms_motion_sync uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .io_in(io_in),
      .io_out(io_out), .io_oe(io_oe), .axis_moving(axis_moving), .move_block(move_block),
      .estop_req(estop_req), .estop_cfg(estop_cfg), .launch_req(launch_req),
      .launch_idx(launch_idx), .irq(irq));
   dms_pin_model pins (.drive_val(io_out), .drive_en(io_oe), .sw_val(sw_val),
      .sw_drv(sw_drv), .pin(io_in));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Expected drive enables for a direction code
   function automatic logic [23:0] oe_exp(input logic [2:0] d);
      return {{8{d[2]}}, {8{d[1]}}, {8{d[0]}}};
   endfunction
   // Assignment word: level at bit 8, index at bits 4:0
   function automatic logic [31:0] asg(input logic l, input logic [4:0] i);
      return {23'h00_0000, l, 3'h0, i};
   endfunction

   // Register bus cycles
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      rd_val = reg_rdata;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Switch action on one pin
   task automatic pin(input int i, input logic v, input logic d);
      @(posedge clk);
      sw_val[i] <= v;
      sw_drv[i] <= d;
   endtask
   // Count stop and launch pulses over a span
   task automatic watch(input int n, input int a);
      n_stop = 0;
      n_launch = 0;
      repeat (n) begin
         @(negedge clk);
         if (estop_req[a] === 1'b1) n_stop++;
         if (launch_req === 1'b1) begin
            n_launch++;
            seen_idx = launch_idx;
         end
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Cut a hang short
   initial begin
      repeat (30000) @(posedge clk);
      error_cnt++;
      $display("[ERR] watchdog exp done got hang");
      give_verdict();
   end

   // Main sequence
   initial begin
      seed = 32'hb830;
      error_cnt = 0;
      checks_done = 0;
      rst = 1'b1;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      axis_moving = 3'h0;
      sw_val = 24'h00_0000;
      sw_drv = 24'h00_0000;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      cyc(1);
      `CHK("io_oe", 24'h00_0000, io_oe)
      `CHK("outs", 8'h00, {move_block, estop_req, launch_req, irq})
      rd(`DMS_A_DIR);
      `CHK("dir", 32'h0000_0000, rd_val)
      $display("test reset done");
      // Every direction code
      for (int d = 0; d < 8; d++) begin
         wr(`DMS_A_DIR, 32'(d));
         cyc(2);
         `CHK("io_oe", oe_exp(3'(d)), io_oe)
      end
      rd(8'h44);
      `CHK("unmapped", 32'h0000_0000, rd_val)
      $display("test direction done");
      // Interlock on random axis, bit and level
      for (int t = 0; t < 4; t++) begin
         ax = (t < 3) ? t : $unsigned($random(seed)) % 3; // Every axis at least once
         b = $unsigned($random(seed)) % 16;
         lv = 1'($random(seed));
         wr(`DMS_A_DIR, 32'(`DMS_DIR_04));
         wr(`DMS_A_ESC, 32'(t));
         wr(8'(`DMS_A_LKA0 + 4 * ax), asg(lv, 5'(b)));
         wr(`DMS_A_IEN, 32'h0000_0007);
         rd(8'(`DMS_A_LKA0 + 4 * ax));
         `CHK("lk_asg", asg(lv, 5'(b)), rd_val)
         `CHK("estop_cfg", 2'(t), estop_cfg)
         @(posedge clk) axis_moving <= 3'(1 << ax);
         pin(b, lv, 1'b1);
         cyc(5);
         `CHK("blk_off", 3'h0, move_block)
         pin(b, !lv, 1'b1);
         wr(`DMS_A_LKEN, 32'(1 << ax));
         cyc(5);
         `CHK("blk_lvl", 3'h0, move_block)
         pin(b, lv, 1'b1);
         watch(6, ax);
         `CHK("stop_cnt", 1, n_stop)
         `CHK("blk_on", 3'(1 << ax), move_block)
         `CHK("irq_on", 1'b1, irq)
         rd(`DMS_A_STAT);
         `CHK("stat", 32'(1 << ax), rd_val)
         wr(`DMS_A_IEN, 32'h0000_0000);
         cyc(1);
         `CHK("irq_mask", 1'b0, irq)
         pin(b, !lv, 1'b1);
         @(posedge clk) axis_moving <= 3'h0;
         cyc(5);
         `CHK("blk_rel", 3'h0, move_block)
         pin(b, lv, 1'b1);
         watch(6, ax);
         `CHK("idle_stop", 0, n_stop)
         `CHK("idle_blk", 3'(1 << ax), move_block)
         @(posedge clk) axis_moving <= 3'(1 << ax);
         watch(4, ax);
         `CHK("rej_stop", 1, n_stop)
         @(posedge clk) axis_moving <= 3'h0;
         pin(b, !lv, 1'b1);
         wr(`DMS_A_LKEN, 32'h0000_0000);
         pin(b, 1'b0, 1'b0);
         cyc(5);
         wr(`DMS_A_CLR, 32'h0000_000f);
         rd(`DMS_A_STAT);
         `CHK("stat_clr", 32'h0000_0000, rd_val)
      end
      $display("test interlock done");
      // Standstill report on bit 9 of axis 2
      wr(`DMS_A_DIR, 32'(`DMS_DIR_06));
      wr(`DMS_A_OUT, 32'h0000_0200);
      wr(`DMS_A_SSEN, 32'h0000_0004);
      cyc(2);
      `CHK("unconf", 1'b1, io_out[9])
      for (int l = 0; l < 2; l++) begin
         wr(`DMS_A_SSEN, 32'h0000_0004);
         wr(`DMS_A_OUT, l ? 32'h0000_0000 : 32'h0000_0200);
         wr(8'(`DMS_A_SSA0 + 8), asg(1'(l), 5'd9));
         cyc(2);
         `CHK("still", 2'b10 | 2'(l), {io_oe[9], io_out[9]})
         `CHK("pin9", 1'(l), io_in[9])
         rd(8'(`DMS_A_SSA0 + 8));
         `CHK("ss_asg", asg(1'(l), 5'd9), rd_val)
         @(posedge clk) axis_moving <= 3'h4;
         cyc(2);
         `CHK("moving", 1'(!l), io_out[9])
         @(posedge clk) axis_moving <= 3'h0;
         wr(`DMS_A_SSEN, 32'h0000_0000);
         cyc(2);
         `CHK("ss_off", 1'(!l), io_out[9])
      end
      $display("test standstill done");
      // Program launch on random input bits
      wr(`DMS_A_DIR, 32'(`DMS_DIR_04));
      wr(`DMS_A_IEN, 32'h0000_0008);
      for (int t = 0; t < 3; t++) begin
         b = $unsigned($random(seed)) % 16;
         c = (b + 1) % 16;
         wr(`DMS_A_LMASK, 32'(1 << b));
         pin(b, 1'b0, 1'b1);
         watch(6, 0);
         `CHK("launch", 1, n_launch)
         `CHK("l_idx", 5'(b), seen_idx)
         `CHK("l_irq", 1'b1, irq)
         rd(`DMS_A_LIDX);
         `CHK("lidx_reg", 32'(b), rd_val)
         pin(c, 1'b0, 1'b1);
         watch(6, 0);
         `CHK("unmasked", 0, n_launch)
         pin(b, 1'b0, 1'b0);
         pin(c, 1'b0, 1'b0);
         watch(6, 0);
         `CHK("rise", 0, n_launch)
         wr(`DMS_A_CLR, 32'h0000_0008);
      end
      $display("test launch done");
      give_verdict();
   end
endmodule
`default_nettype wire
